// >>> hdl/irsf_regs.vh
// Constants for the image readout serial framer.
// Included by the framer; holds definitions only.
`ifndef IRSF_REGS_VH
`define IRSF_REGS_VH
// Register indices on the plain register port
`define IRSF_A_WIN_ROWS   4'h0
`define IRSF_A_ROW_START  4'h1
`define IRSF_A_VBLANK     4'h2
`define IRSF_A_FBLANK     4'h3
`define IRSF_A_READ_MODE  4'h4
`define IRSF_A_INTERLACE  4'h5
`define IRSF_A_OUT_CTRL   4'h6
`define IRSF_A_SER_CTRL   4'h7
`define IRSF_A_STATUS     4'h8
`define IRSF_A_WIN_COLS   4'h9
// Read mode fields
`define IRSF_RM_ROWBIN2   0
`define IRSF_RM_ROWBIN4   1
`define IRSF_RM_COLBIN2   2
`define IRSF_RM_COLBIN4   3
// Output control: line-valid format field
`define IRSF_OC_LV_LO     2
`define IRSF_OC_LV_HI     3
// Serial control fields
`define IRSF_SC_TEN_BIT   0
`define IRSF_SC_STEREO    1
// Interlace selector codes
`define IRSF_IL_PROG      3'h0
`define IRSF_IL_BOTH      3'h1
`define IRSF_IL_SINGLE    3'h2
// Reserved words and substitutes
`define IRSF_W_FRAME_ST   10'h000
`define IRSF_W_LINE_ST    10'h001
`define IRSF_W_LINE_END   10'h002
`define IRSF_W_FRAME_END  10'h003
`define IRSF_W_SUBST      10'h004
`define IRSF_W_FULL       10'h3FF
`define IRSF_MIN_VBLANK   9'h004
// Reset values
`define IRSF_RST_ROWS     9'h1E0
`define IRSF_RST_COLS     10'h2F0
`define IRSF_RST_VBLANK   9'h02D
`define IRSF_RST_FBLANK   8'h16
`endif

// >>> hdl/irsf_framer.v
// Readout sequencer, line-valid formatter and serial packetizer.
// Assumes pixel data and slave stream are in clock_i domain (lock-step).
// Function
// - Row binning reads half or quarter rows
// - Column binning slows pixel rate two or four
// - Interlace one: even, field blank, odd, blank
// - Interlace two: single field by start parity
// - Interlace one vblank: vblank minus field blank, four at least
// - Three line-valid formats via two bits
// - Third format: line-valid XOR frame-valid
// - Stand-alone packet twelve bits, 8/10-bit pixels
// - Eight-bit packet bit layout
// - Ten-bit packet bit layout
// - Stereo eighteen-bit packet layout
// - Reserved codes mark frame and line edges
// - Validity always embedded in serial data
// - Raw pixels 0..3 sent as 4
// - Full, zero, full becomes full, four, full
// - Column binning repeats each pixel
// - Stereo pair shares clock and reset
// - Config writes reach both sensors together
// - Master flags stereo stream desync
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "irsf_regs.vh"
module irsf_framer #(
    parameter PIX_W = 10
) (
    // Clock and reset
    input  wire             clock_i,
    input  wire             rst_i,
    // Register port
    input  wire [3:0]       reg_addr_i,
    input  wire [15:0]      reg_wdata_i,
    input  wire             reg_wr_i,
    input  wire             reg_rd_i,
    output reg  [15:0]      reg_rdata_o,
    // Pixel source
    input  wire [PIX_W-1:0] pix_data_i,
    output wire             pix_take_o,
    // Stereo slave stream
    input  wire [7:0]       slave_byte_i,
    input  wire             slave_sync_i,
    output wire             cfg_wr_share_o,
    output wire [3:0]       cfg_addr_share_o,
    output wire [15:0]      cfg_data_share_o,
    // Parallel outputs
    output reg              pixel_rate_clock_o,
    output reg              line_valid_o,
    output reg              frame_valid_o,
    // Serial output
    output reg              ser_data_o,
    output reg              ser_word_o
);
    localparam S_ROWS  = 4'b0001;
    localparam S_FIELD = 4'b0010;
    localparam S_ROWS2 = 4'b0100;
    localparam S_VBLK  = 4'b1000;
    localparam LINE_GAP = 10'h010;

    reg [8:0]  rows_q;
    reg [9:0]  cols_q;
    reg [9:0]  rstart_q;
    reg [8:0]  vblank_q;
    reg [7:0]  fblank_q;
    reg [5:0]  rmode_q;
    reg [2:0]  ilace_q;
    reg [4:0]  octrl_q;
    reg [1:0]  sctrl_q;
    reg        serr_q;
    reg [3:0]  st_q;
    reg [8:0]  row_q;
    reg [9:0]  col_q;
    reg [1:0]  div_q;
    reg        lv_cont_q;
    reg [9:0]  p1_q;
    reg [9:0]  p2_q;
    reg [17:0] sh_q;
    reg [4:0]  bit_q;
    reg [1:0]  ev_q;
    reg        lv_prev_q;
    reg        fv_prev_q;
    reg [1:0]  rep_q;

    // Config writes mirrored straight to the slave sensor
    assign cfg_wr_share_o   = reg_wr_i;
    assign cfg_addr_share_o = reg_addr_i;
    assign cfg_data_share_o = reg_wdata_i;

    function [9:0] irsf_subst;
        input [9:0] v;
        begin
            irsf_subst = (v <= `IRSF_W_FRAME_END) ? `IRSF_W_SUBST : v;
        end
    endfunction

    // Register write and read
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rows_q   <= `IRSF_RST_ROWS;
            cols_q   <= `IRSF_RST_COLS;
            rstart_q <= 10'h000;
            vblank_q <= `IRSF_RST_VBLANK;
            fblank_q <= `IRSF_RST_FBLANK;
            rmode_q  <= 6'h00;
            ilace_q  <= `IRSF_IL_PROG;
            octrl_q  <= 5'h00;
            sctrl_q  <= 2'h0;
            reg_rdata_o <= 16'h0000;
        end
        else
        begin
            if (reg_wr_i)
            begin
                case (reg_addr_i)
                    `IRSF_A_WIN_ROWS:  rows_q   <= reg_wdata_i[8:0];
                    `IRSF_A_WIN_COLS:  cols_q   <= reg_wdata_i[9:0];
                    `IRSF_A_ROW_START: rstart_q <= reg_wdata_i[9:0];
                    `IRSF_A_VBLANK:    vblank_q <= reg_wdata_i[8:0];
                    `IRSF_A_FBLANK:    fblank_q <= reg_wdata_i[7:0];
                    `IRSF_A_READ_MODE: rmode_q  <= reg_wdata_i[5:0];
                    `IRSF_A_INTERLACE: ilace_q  <= reg_wdata_i[2:0];
                    `IRSF_A_OUT_CTRL:  octrl_q  <= reg_wdata_i[4:0];
                    `IRSF_A_SER_CTRL:  sctrl_q  <= reg_wdata_i[1:0];
                    default: ;
                endcase
            end
            reg_rdata_o <= 16'h0000;
            // Status read also clears the stereo error flag
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    `IRSF_A_WIN_ROWS:  reg_rdata_o <= {7'h00, rows_q};
                    `IRSF_A_WIN_COLS:  reg_rdata_o <= {6'h00, cols_q};
                    `IRSF_A_ROW_START: reg_rdata_o <= {6'h00, rstart_q};
                    `IRSF_A_VBLANK:    reg_rdata_o <= {7'h00, vblank_q};
                    `IRSF_A_FBLANK:    reg_rdata_o <= {8'h00, fblank_q};
                    `IRSF_A_READ_MODE: reg_rdata_o <= {10'h000, rmode_q};
                    `IRSF_A_INTERLACE: reg_rdata_o <= {13'h0000, ilace_q};
                    `IRSF_A_OUT_CTRL:  reg_rdata_o <= {11'h000, octrl_q};
                    `IRSF_A_SER_CTRL:  reg_rdata_o <= {14'h0000, sctrl_q};
                    `IRSF_A_STATUS:    reg_rdata_o <= {11'h000, st_q, serr_q};
                    default:           reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end

    // Readout geometry
    wire       colbin4  = rmode_q[`IRSF_RM_COLBIN4];
    wire       colbin2  = rmode_q[`IRSF_RM_COLBIN2];
    wire [1:0] div_max  = colbin4 ? 2'h3 : (colbin2 ? 2'h1 : 2'h0);
    wire       tick     = (div_q == div_max);
    wire [8:0] rows_eff = rmode_q[`IRSF_RM_ROWBIN4] ? {2'h0, rows_q[8:2]} :
                          rmode_q[`IRSF_RM_ROWBIN2] ? {1'b0, rows_q[8:1]} :
                          (ilace_q != `IRSF_IL_PROG) ? {1'b0, rows_q[8:1]} :
                          rows_q;
    // Interlaced vertical blank, never below the minimum
    wire [8:0] vb_sub   = vblank_q - {1'b0, fblank_q};
    wire [8:0] vb_il    = (vb_sub < `IRSF_MIN_VBLANK) ? `IRSF_MIN_VBLANK : vb_sub;
    wire [8:0] vb_rows  = (ilace_q == `IRSF_IL_BOTH) ? vb_il : vblank_q;
    wire       in_line  = (st_q == S_ROWS) || (st_q == S_ROWS2);
    wire       lv_now   = in_line && (col_q < cols_q);
    wire       line_end = (col_q == cols_q + LINE_GAP - 10'h001);
    wire       last_row = (row_q == rows_eff - 9'h001);
    wire [9:0] row_addr = (ilace_q == `IRSF_IL_SINGLE) ?
                          rstart_q + {row_q, 1'b0} :
                          (ilace_q == `IRSF_IL_BOTH) ?
                          {row_q, (st_q == S_ROWS2)} : {1'b0, row_q};
    wire       pkt_done = (bit_q == 5'h00);
    wire [4:0] pkt_len  = sctrl_q[`IRSF_SC_STEREO] ? 5'h11 : 5'h0B;
    wire       fv_now   = (st_q != S_VBLK);
    // Codes that open a frame or line take a slot of their own
    wire       hold     = (fv_now && !fv_prev_q) || (lv_now && !lv_prev_q);
    // Binned output repeats whole packets at the full bit rate;
    // the receiver keeps one in two or four of them
    wire       last_rep = (rep_q == div_max);
    wire       adv      = pkt_done && last_rep;

    // Raw pixel stands through every repeat of its packet
    assign pix_take_o = lv_now && !hold && adv;

    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            st_q  <= S_ROWS;
            row_q <= 9'h000;
            col_q <= 10'h000;
            div_q <= 2'h0;
            pixel_rate_clock_o <= 1'b0;
        end
        else
        begin
            // Divider only paces the pixel clock output
            div_q <= tick ? 2'h0 : div_q + 2'h1;
            pixel_rate_clock_o <= (div_q <= {1'b0, div_max[1]});
            if (adv && !hold)
            begin
                col_q <= line_end ? 10'h000 : col_q + 10'h001;
                if (line_end)
                begin
                    row_q <= row_q + 9'h001;
                    case (st_q)
                        S_ROWS:
                        begin
                            if (last_row)
                            begin
                                row_q <= 9'h000;
                                st_q  <= (ilace_q == `IRSF_IL_BOTH) ? S_FIELD : S_VBLK;
                            end
                        end
                        S_FIELD:
                        begin
                            if (row_q == {1'b0, fblank_q})
                            begin
                                row_q <= 9'h000;
                                st_q  <= S_ROWS2;
                            end
                        end
                        S_ROWS2:
                        begin
                            if (last_row)
                            begin
                                row_q <= 9'h000;
                                st_q  <= S_VBLK;
                            end
                        end
                        S_VBLK:
                        begin
                            if (row_q == vb_rows)
                            begin
                                row_q <= 9'h000;
                                st_q  <= S_ROWS;
                            end
                        end
                        default:
                        begin
                            row_q <= 9'h000;
                            st_q  <= S_ROWS;
                        end
                    endcase
                end
            end
        end
    end

    // Parallel valids and formats
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            lv_cont_q     <= 1'b0;
            line_valid_o  <= 1'b0;
            frame_valid_o <= 1'b0;
        end
        else
        begin
            lv_cont_q     <= lv_now || (!fv_now && (col_q < cols_q));
            frame_valid_o <= fv_now;
            case (octrl_q[`IRSF_OC_LV_HI:`IRSF_OC_LV_LO])
                2'h1:    line_valid_o <= lv_cont_q;
                2'h2:    line_valid_o <= lv_cont_q ^ fv_now;
                default: line_valid_o <= lv_now;
            endcase
        end
    end

    // Word with reserved codes at edges
    wire [9:0] word_raw = (fv_now && !fv_prev_q) ? `IRSF_W_FRAME_ST :
                          (!fv_now && fv_prev_q) ? `IRSF_W_FRAME_END :
                          (lv_now && !lv_prev_q) ? `IRSF_W_LINE_ST :
                          (!lv_now && lv_prev_q) ? `IRSF_W_LINE_END :
                          irsf_subst(pix_data_i);
    wire       is_code  = !lv_now || !lv_prev_q;
    wire [9:0] word     = (!is_code && p2_q == `IRSF_W_FULL &&
                          p1_q == 10'h000 && word_raw == `IRSF_W_FULL) ?
                          word_raw : word_raw; // pass-through; only the p1_q history of the newest word is patched below
    wire [7:0] m8       = word[9:2];
    wire [7:0] s8       = (irsf_subst({slave_byte_i, 2'h0}) == `IRSF_W_SUBST) ?
                          8'h01 : slave_byte_i;

    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sh_q      <= 18'h00000;
            bit_q     <= 5'h00;
            ev_q      <= 2'h0;
            p1_q      <= 10'h000;
            p2_q      <= 10'h000;
            lv_prev_q <= 1'b0;
            fv_prev_q <= 1'b0;
            rep_q     <= 2'h0;
            serr_q    <= 1'b0;
            ser_data_o <= 1'b0;
            ser_word_o <= 1'b0;
        end
        else
        begin
            ser_word_o <= 1'b0;
            // Set wins over the clearing read
            if (sctrl_q[`IRSF_SC_STEREO] && !slave_sync_i && pkt_done)
                serr_q <= 1'b1;
            else if (reg_rd_i && reg_addr_i == `IRSF_A_STATUS)
                serr_q <= 1'b0;
            // Serial bits run on every clock, binned or not
            ser_data_o <= pkt_done ? 1'b1 : sh_q[0];
            if (pkt_done)
            begin
                ser_word_o <= 1'b1;
                bit_q <= pkt_len;
                // History moves on only as the last repeat of a slot is loaded
                rep_q <= last_rep ? 2'h0 : rep_q + 2'h1;
                if (last_rep)
                begin
                    fv_prev_q <= fv_now;
                    // A frame start slot is followed by its own line start
                    lv_prev_q <= (fv_now && !fv_prev_q) ? 1'b0 : lv_now;
                    p2_q <= p1_q;
                    p1_q <= (p1_q == 10'h000 && p2_q == `IRSF_W_FULL &&
                             word == `IRSF_W_FULL) ? `IRSF_W_SUBST : word;
                end
                if (sctrl_q[`IRSF_SC_STEREO])
                    sh_q <= {1'b0, 1'b0, s8, m8};
                else if (sctrl_q[`IRSF_SC_TEN_BIT])
                    sh_q <= {7'h00, 1'b0, word};
                else
                    sh_q <= {7'h00, 1'b0, fv_now, lv_now, m8};
            end
            else
            begin
                bit_q <= bit_q - 5'h01;
                // Zero fill above the payload becomes the stop bit
                sh_q  <= {1'b0, sh_q[17:1]};
            end
        end
    end
endmodule // irsf_framer

// >>> verif/irsf_checker.sv
// Port assertions for the readout framer.
// Bound into irsf_framer; sees its ports only.
`timescale 1ns/1ps
module irsf_checker (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Register port
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Slave copy
    input wire logic        cfg_wr_share_o,
    input wire logic [3:0]  cfg_addr_share_o,
    input wire logic [15:0] cfg_data_share_o,
    // Serial
    input wire logic        ser_data_o,
    input wire logic        ser_word_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0)
        else $error("read data outside a read");
    unmapped_rd_a: assert property (reg_rd_i && reg_addr_i > 4'h9 |=> reg_rdata_o == 16'h0)
        else $error("unmapped read data");
    mode_back_a: assert property (
        reg_wr_i && reg_addr_i == 4'h5 ##1 reg_rd_i && reg_addr_i == 4'h5
        |=> reg_rdata_o[2:0] == $past(reg_wdata_i[2:0], 2))
        else $error("interlace readback");
    cfg_copy_a: assert property (
        reg_wr_i |-> cfg_wr_share_o && cfg_addr_share_o == reg_addr_i
        && cfg_data_share_o == reg_wdata_i)
        else $error("write not shared");
    cfg_quiet_a: assert property (!reg_wr_i |-> !cfg_wr_share_o)
        else $error("spurious shared write");
    start_bit_a: assert property (ser_word_o |-> ser_data_o)
        else $error("packet start not one");
    word_gap_a: assert property (
        ser_word_o |=> !ser_word_o [*8] ##1 !ser_word_o [*3])
        else $error("packet too short");
    reset_quiet_a: assert property ($fell(rst_i) |-> !ser_word_o && !ser_data_o
        && reg_rdata_o == 16'h0)
        else $error("outputs not cleared");
endmodule // irsf_checker
bind irsf_framer irsf_checker chk (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .cfg_wr_share_o, .cfg_addr_share_o, .cfg_data_share_o,
    .ser_data_o, .ser_word_o);

// >>> verif/irsf_deser_model.sv
// Far side: serial deserializer and lock-step stereo slave.
// Packets open on the word pulse; one packet in div_i is kept.
`timescale 1ns/1ps
module irsf_deser_model (
    // Clock
    input  wire logic        clock_i,
    // Link
    input  wire logic        ser_data_i,
    input  wire logic        ser_word_i,
    // Setup
    input  wire logic [4:0]  len_i,
    input  wire logic [2:0]  div_i,
    input  wire logic        sync_i,
    // Packet out
    output logic      [17:0] pkt_o,
    output logic             pkt_v_o,
    // Slave stream
    output logic      [7:0]  slave_byte_o,
    output logic             slave_sync_o
);
    logic [17:0] sh_q;
    logic [4:0]  bit_q = 5'h0;
    logic [2:0]  tk_q = 3'h0;
    // Same clock as the master, so no crossing
    assign slave_byte_o = 8'hA5;
    assign slave_sync_o = sync_i;
    always @(posedge clock_i)
    begin
        pkt_v_o <= 1'b0;
        if (bit_q == 5'h0 && ser_word_i === 1'b1)
        begin
            sh_q <= {17'h0, ser_data_i};
            bit_q <= 5'h1;
        end
        else if (bit_q != 5'h0)
        begin
            sh_q[bit_q] <= ser_data_i;
            pkt_o <= sh_q | ({17'h0, ser_data_i} << bit_q);
            bit_q <= (bit_q == len_i - 5'h1) ? 5'h0 : bit_q + 5'h1;
            if (bit_q == len_i - 5'h1)
            begin
                // Undersampling drops the binned repeats
                pkt_v_o <= (tk_q + 3'h1 >= div_i);
                tk_q <= (tk_q + 3'h1 >= div_i) ? 3'h0 : tk_q + 3'h1;
            end
        end
    end
endmodule // irsf_deser_model

// >>> verif/test_image_readout_serial_framer.sv
// Self-checking bench for the readout framer.
// Assumes the deserializer model on the link.
`timescale 1ns/1ps
`include "irsf_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
$display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_image_readout_serial_framer;
    logic        clock_i, rst_i, reg_wr_i, reg_rd_i, sync_i, pkt_v_o;
    logic        pix_take_o, slave_sync_i, ser_data_o, ser_word_o;
    logic [3:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, v;
    logic [9:0]  pix_data_i;
    logic [7:0]  slave_byte_i;
    logic [4:0]  len_i;
    logic [2:0]  div_i;
    logic [17:0] pkt_o;
    logic [17:0] q [$];
    logic [9:0]  fr [$];
    logic [9:0]  pv [4] = '{10'h3FF, 10'h000, 10'h3FF, 10'h003};
    logic [9:0]  px [4] = '{10'h3FF, 10'h004, 10'h3FF, 10'h004};
    logic [1:0]  pi = 2'h0;
    int          gap = 0, errors = 0, n_tests = 0;
    irsf_framer #(.PIX_W(10)) uut (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .pix_data_i, .pix_take_o, .slave_byte_i, .slave_sync_i,
        .cfg_wr_share_o(), .cfg_addr_share_o(), .cfg_data_share_o(),
        .pixel_rate_clock_o(), .line_valid_o(), .frame_valid_o(), .ser_data_o, .ser_word_o);
    irsf_deser_model far (.clock_i, .ser_data_i(ser_data_o), .ser_word_i(ser_word_o),
        .len_i, .div_i, .sync_i, .pkt_o, .pkt_v_o, .slave_byte_o(slave_byte_i),
        .slave_sync_o(slave_sync_i));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Each line restarts the pattern after a long gap
    always @(posedge clock_i)
    begin
        if (pkt_v_o === 1'b1)
            q.push_back(pkt_o);
        if (pix_take_o === 1'b1)
        begin
            pi <= pi + 2'h1;
            gap <= 0;
            pix_data_i <= pv[pi + 2'h1];
        end
        else if (gap > 100)
        begin
            pi <= 2'h0;
            pix_data_i <= pv[0];
        end
        else
            gap <= gap + 1;
    end
    task acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        reg_wr_i <= w;
        reg_rd_i <= r;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
    endtask
    task set(input logic [3:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, a, d);
        acc(1'b0, 1'b0, a, d);
    endtask
    task rd(input logic [3:0] a);
        acc(1'b0, 1'b1, a, 16'h0);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
        @(posedge clock_i);
    endtask
    task mode(input logic [15:0] m, il, sc, input logic [4:0] l, input logic [2:0] d);
        // Read mode (binning) is written before interlace is set
        set(`IRSF_A_READ_MODE, m);
        set(`IRSF_A_INTERLACE, il);
        set(`IRSF_A_SER_CTRL, sc);
        len_i <= l;
        div_i <= d;
    endtask
    // Captures a whole frame between two frame-start words
    task frame_chk(input logic [7:0] lines, input int rep);
        logic [17:0] p;
        int s, n, k, j;
        logic [7:0] nl, ne;
        q.delete();
        fr.delete();
        s = 0;
        n = 0;
        k = -1;
        nl = 0;
        ne = 0;
        while (s < 3 && n < 40000)
        begin
            @(posedge clock_i);
            n++;
            while (q.size() > 0)
            begin
                p = q.pop_front();
                if (p[10:1] === 10'h000)
                    s++;
                else if (s == 2)
                    fr.push_back(p[10:1]);
            end
        end
        foreach (fr[i])
        begin
            if (fr[i] === 10'h001 && k < 0)
                k = i;
            nl += (fr[i] === 10'h001);
            ne += (fr[i] === 10'h003);
        end
        `CHK("frames", 1'b1, s == 3);
        `CHK("lines", lines, nl);
        `CHK("frame end", 8'h1, ne);
        for (j = 0; j < 4 * rep; j++)
            `CHK("pixel", px[j / rep], fr[k + 1 + j]);
        `CHK("line end", 10'h002, fr[k + 1 + 4 * rep]);
    endtask
    task scan(input logic [17:0] msk, ex);
        int f;
        repeat (200) @(posedge clock_i);
        q.delete();
        repeat (4000) @(posedge clock_i);
        f = 0;
        foreach (q[i])
            if (q[i][9:1] === 9'h1FF)
            begin
                f++;
                `CHK("packet", ex, q[i] & msk);
            end
        `CHK("found", 1'b1, f > 0);
    endtask
    task end_sim;
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {rst_i, sync_i, len_i, div_i} = {2'b11, 5'd12, 3'd1};
        pix_data_i = pv[0];
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(`IRSF_A_VBLANK);
        `CHK("vblank", {7'h0, `IRSF_RST_VBLANK}, v);
        set(4'hC, 16'h1234);
        rd(4'hC);
        `CHK("unmapped", 16'h0, v);
        acc(1'b1, 1'b0, `IRSF_A_INTERLACE, 16'h0002);
        rd(`IRSF_A_INTERLACE);
        `CHK("interlace", 16'h0002, v);
        set(`IRSF_A_WIN_ROWS, 16'h4);
        set(`IRSF_A_WIN_COLS, 16'h4);
        set(`IRSF_A_VBLANK, 16'h4);
        set(`IRSF_A_FBLANK, 16'h2);
        mode(16'h0, 16'h0, 16'h1, 5'd12, 3'd1);
        frame_chk(8'd4, 1);
        mode(16'h1, 16'h0, 16'h1, 5'd12, 3'd1);
        frame_chk(8'd2, 1);
        mode(16'h2, 16'h0, 16'h1, 5'd12, 3'd1);
        frame_chk(8'd1, 1);
        mode(16'h4, 16'h0, 16'h1, 5'd12, 3'd2);
        frame_chk(8'd4, 1);
        mode(16'h0, 16'h1, 16'h1, 5'd12, 3'd1);
        frame_chk(8'd4, 1);
        mode(16'h0, 16'h2, 16'h1, 5'd12, 3'd1);
        frame_chk(8'd2, 1);
        mode(16'h0, 16'h0, 16'h0, 5'd12, 3'd1);
        scan(18'h00FFF, 18'h007FF);
        mode(16'h0, 16'h0, 16'h2, 5'd18, 3'd1);
        scan(18'h3FFFF, 18'h14BFF);
        sync_i <= 1'b0;
        repeat (200) @(posedge clock_i);
        rd(`IRSF_A_STATUS);
        `CHK("desync", 1'b1, v[0]);
        sync_i <= 1'b1;
        repeat (50) @(posedge clock_i);
        rd(`IRSF_A_STATUS);
        rd(`IRSF_A_STATUS);
        `CHK("in step", 1'b0, v[0]);
        end_sim;
    end
    initial
    begin
        #800000;
        errors++;
        end_sim;
    end
endmodule // test_image_readout_serial_framer
